//--- inc/pdmux_consts.svh
// register offsets, field positions and reset values of the port d override block
`ifndef PDMUX_CONSTS_SVH
`define PDMUX_CONSTS_SVH

`define PD_OFF_DATA      32'h0000_0000
`define PD_OFF_DIR       32'h0000_0004
`define PD_OFF_CTRL      32'h0000_0008
`define PD_OFF_PINS      32'h0000_000C
`define PD_OFF_MASK      32'h0000_0010
`define PD_OFF_STATUS    32'h0000_0014

`define PD_CTRL_PUD_BIT  0
`define PD_CTRL_GRP_BIT  1

`define PD_RST_DATA      8'h00
`define PD_RST_DIR       8'h00
`define PD_RST_PUD       1'b0
`define PD_RST_GRP       1'b0
`define PD_RST_MASK      8'h00

`define PD_PIN_COUNT     8

`endif

//--- inc/pdmux_pkg.sv
// types shared by the port d override block
`default_nettype none
package pdmux_pkg;

  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic timer2_compare_a_en;
    logic timer2_compare_a_out;
    logic timer2_compare_b_en;
    logic timer2_compare_b_out;
    logic timer1_compare_a_en;
    logic timer1_compare_a_out;
    logic timer1_compare_b_en;
    logic timer1_compare_b_out;
  } timer_cmp_t;

  typedef struct packed {
    logic serial0_transmitter_on;
    logic serial0_transmit_line;
    logic serial0_receiver_on;
    logic serial1_transmitter_on;
    logic serial1_transmit_line;
    logic serial1_receiver_on;
    logic serial1_sync_mode;
    logic serial1_clock_out;
  } serial_ctl_t;

  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic pin_value_override_enable;
    logic pin_value_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } override_t;

  typedef struct packed {
    logic [7:0]  data;
    logic [7:0]  dir;
    logic        global_pullup_disable;
    logic        pin_change_group3_enable;
    logic [7:0]  mask;
    logic [7:0]  sync_first;
    logic [7:0]  sync_second;
    logic [31:0] prdata;
    logic [7:0]  pad_out;
    logic [7:0]  pad_oe;
    logic [7:0]  pad_pullup;
    logic [7:0]  pad_input_on;
    logic        serial0_receive_line;
    logic        serial1_receive_line;
    logic        serial1_external_clock;
    logic        timer1_capture_trigger;
    logic        external_irq_zero;
    logic        external_irq_one;
    logic [7:0]  pin_change_source;
  } state_t;

endpackage : pdmux_pkg
`default_nettype wire

//--- rtl/pin_override_cell.sv
// one pin's override multiplexer: pull-up, direction, value and input enable
`timescale 1ns/1ps
`default_nettype none

module pin_override_cell
  import pdmux_pkg::*;
(
  // overrides from the alternate functions
  input  wire pdmux_pkg::override_t ovr,
  // port register settings
  input  wire logic                 data_bit,
  input  wire logic                 dir_bit,
  input  wire logic                 global_pullup_disable,
  input  wire logic                 buffers_off,
  // resolved pin controls
  output logic                      pullup_on,
  output logic                      drive_on,
  output logic                      drive_value,
  output logic                      input_on
);

  import pdmux_pkg::*;

  always_comb begin
    // plain port pull-up needs input, data one and no global disable
    if (ovr.pullup_override_enable) begin // [RQ16]
      pullup_on = ovr.pullup_override_value;
    end else begin
      pullup_on = ~dir_bit & data_bit & ~global_pullup_disable; // [RQ15]
    end
    drive_on    = ovr.direction_override_enable ? ovr.direction_override_value
                                                : dir_bit; // [RQ16]
    drive_value = ovr.pin_value_override_enable ? ovr.pin_value_override_value
                                                : data_bit; // [RQ16]
    input_on    = ovr.input_enable_override_enable ? ovr.input_enable_override_value
                                                   : ~buffers_off; // [RQ16]
  end

endmodule : pin_override_cell
`default_nettype wire

//--- rtl/port_d_alternate_function_override.sv
// port d alternate function override logic with apb register access
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "pdmux_consts.svh"

// Function
// RQ1 - pin 7 drives timer2 compare A waveform
// RQ2 - pin 6 drives timer2 compare B waveform
// RQ3 - pin 6 input feeds timer1 capture trigger
// RQ4 - pin 5 drives timer1 compare A waveform
// RQ5 - pin 4 drives timer1 compare B waveform
// RQ6 - pin 4 serial1 clock, direction picks role
// RQ7 - serial1 transmitter forces pin 3 output
// RQ8 - serial1 receiver forces pin 2 input, pull-up kept
// RQ9 - serial0 transmitter forces pin 1 output
// RQ10 - serial0 receiver forces pin 0 input
// RQ11 - pin 0 pull-up follows data bit, gated
// RQ12 - each pin feeds pin-change source, buffer on
// RQ13 - pin 3 feeds irq one, buffer on
// RQ14 - pin 2 feeds irq zero, buffer on
// RQ15 - global pull-up disable turns every pull-up off
// RQ16 - override enable selects override value per control
// RQ17 - serial forcing beats timer compare outputs
module port_d_alternate_function_override
  import pdmux_pkg::*;
#(
  parameter int PINS = `PD_PIN_COUNT
) (
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // apb slave
  input  wire pdmux_pkg::apb_req_t    apb_in,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // pads
  input  wire logic [PINS-1:0]        pad_in,
  output logic [PINS-1:0]             pad_out,
  output logic [PINS-1:0]             pad_oe,
  output logic [PINS-1:0]             pad_pullup,
  output logic [PINS-1:0]             pad_input_on,
  // sleep logic asks for input buffers off
  input  wire logic                   input_buffers_off,
  // timers
  input  wire pdmux_pkg::timer_cmp_t  timer_in,
  output logic                        timer1_capture_trigger,
  // serial units
  input  wire pdmux_pkg::serial_ctl_t serial_in,
  output logic                        serial0_receive_line,
  output logic                        serial1_receive_line,
  output logic                        serial1_external_clock,
  // interrupt controller
  input  wire logic                   external_irq_zero_en,
  input  wire logic                   external_irq_one_en,
  output logic                        external_irq_zero,
  output logic                        external_irq_one,
  output logic [PINS-1:0]             pin_change_source
);

  import pdmux_pkg::*;

  // the override table is wired per pin, so no other width can be served
  if (PINS != 8) begin : g_pins_check
    $error("port d override serves exactly eight pins");
  end

  state_t          st;
  state_t          st_next;
  override_t [7:0] ovr;
  logic      [7:0] cell_pullup;
  logic      [7:0] cell_drive;
  logic      [7:0] cell_value;
  logic      [7:0] cell_input;
  logic      [7:0] pin_di;
  logic      [7:0] pc_enable;
  logic            wr_access;
  logic            rd_setup;
  logic            addr_ok;
  logic [31:0]     rd_value;
  logic            xck_master;
  logic            xck_slave;

  // ---------------- apb decode ----------------
  // zero wait states: read data is latched in the setup phase
  assign pready    = 1'b1;
  assign wr_access = apb_in.psel & apb_in.penable & apb_in.pwrite;
  assign rd_setup  = apb_in.psel & ~apb_in.penable & ~apb_in.pwrite;

  always_comb begin
    addr_ok  = 1'b1;
    rd_value = 32'h0000_0000;
    if (apb_in.paddr == `PD_OFF_DATA) begin
      rd_value = {24'h00_0000, st.data};
    end else if (apb_in.paddr == `PD_OFF_DIR) begin
      rd_value = {24'h00_0000, st.dir};
    end else if (apb_in.paddr == `PD_OFF_CTRL) begin
      rd_value = {30'h0000_0000, st.pin_change_group3_enable, st.global_pullup_disable};
    end else if (apb_in.paddr == `PD_OFF_PINS) begin
      // reads the synchronised pad level, even with the buffer off
      rd_value = {24'h00_0000, st.sync_second};
    end else if (apb_in.paddr == `PD_OFF_MASK) begin
      rd_value = {24'h00_0000, st.mask};
    end else if (apb_in.paddr == `PD_OFF_STATUS) begin
      // effective pad drive after all overrides
      rd_value = {24'h00_0000, st.pad_oe};
    end else begin
      addr_ok  = 1'b0;
    end
  end

  assign pslverr = apb_in.psel & apb_in.penable & ~addr_ok;

  // ---------------- alternate function overrides ----------------
  assign pc_enable  = st.mask & {8{st.pin_change_group3_enable}};
  // serial1 clock only in synchronous mode, direction picks master or slave
  assign xck_master = serial_in.serial1_sync_mode & st.dir[4];
  assign xck_slave  = serial_in.serial1_sync_mode & ~st.dir[4];

  always_comb begin
    ovr = '0;

    // pin 7: timer2 compare A, reaches pad only through the direction bit
    ovr[7].pin_value_override_enable    = timer_in.timer2_compare_a_en; // [RQ1]
    ovr[7].pin_value_override_value     = timer_in.timer2_compare_a_out; // [RQ1]
    ovr[7].input_enable_override_enable = pc_enable[7]; // [RQ12]
    ovr[7].input_enable_override_value  = 1'b1;

    // pin 6: timer2 compare B
    ovr[6].pin_value_override_enable    = timer_in.timer2_compare_b_en; // [RQ2]
    ovr[6].pin_value_override_value     = timer_in.timer2_compare_b_out; // [RQ2]
    ovr[6].input_enable_override_enable = pc_enable[6]; // [RQ12]
    ovr[6].input_enable_override_value  = 1'b1;

    // pin 5: timer1 compare A
    ovr[5].pin_value_override_enable    = timer_in.timer1_compare_a_en; // [RQ4]
    ovr[5].pin_value_override_value     = timer_in.timer1_compare_a_out; // [RQ4]
    ovr[5].input_enable_override_enable = pc_enable[5]; // [RQ12]
    ovr[5].input_enable_override_value  = 1'b1;

    // pin 4: serial1 clock master wins over timer1 compare B
    if (xck_master) begin
      ovr[4].pin_value_override_enable  = 1'b1; // [RQ6] [RQ17]
      ovr[4].pin_value_override_value   = serial_in.serial1_clock_out; // [RQ6]
    end else begin
      ovr[4].pin_value_override_enable  = timer_in.timer1_compare_b_en; // [RQ5]
      ovr[4].pin_value_override_value   = timer_in.timer1_compare_b_out; // [RQ5]
    end
    ovr[4].input_enable_override_enable = pc_enable[4] | xck_slave; // [RQ12] [RQ6]
    ovr[4].input_enable_override_value  = 1'b1;

    // pin 3: serial1 transmit forces output whatever the direction bit
    ovr[3].direction_override_enable    = serial_in.serial1_transmitter_on; // [RQ7]
    ovr[3].direction_override_value     = 1'b1;
    ovr[3].pin_value_override_enable    = serial_in.serial1_transmitter_on; // [RQ7]
    ovr[3].pin_value_override_value     = serial_in.serial1_transmit_line; // [RQ7]
    ovr[3].input_enable_override_enable = external_irq_one_en | pc_enable[3]; // [RQ13] [RQ12]
    ovr[3].input_enable_override_value  = 1'b1;

    // pin 2: serial1 receive forces input, pull-up still from data bit
    ovr[2].pullup_override_enable       = serial_in.serial1_receiver_on; // [RQ8]
    ovr[2].pullup_override_value        = st.data[2] & ~st.global_pullup_disable; // [RQ8] [RQ15]
    ovr[2].direction_override_enable    = serial_in.serial1_receiver_on; // [RQ8]
    ovr[2].direction_override_value     = 1'b0;
    ovr[2].input_enable_override_enable = external_irq_zero_en | pc_enable[2]; // [RQ14] [RQ12]
    ovr[2].input_enable_override_value  = 1'b1;

    // pin 1: serial0 transmit forces output
    ovr[1].direction_override_enable    = serial_in.serial0_transmitter_on; // [RQ9]
    ovr[1].direction_override_value     = 1'b1;
    ovr[1].pin_value_override_enable    = serial_in.serial0_transmitter_on; // [RQ9]
    ovr[1].pin_value_override_value     = serial_in.serial0_transmit_line; // [RQ9]
    ovr[1].input_enable_override_enable = pc_enable[1]; // [RQ12]
    ovr[1].input_enable_override_value  = 1'b1;

    // pin 0: serial0 receive forces input, pull-up still from data bit
    ovr[0].pullup_override_enable       = serial_in.serial0_receiver_on; // [RQ11]
    ovr[0].pullup_override_value        = st.data[0] & ~st.global_pullup_disable; // [RQ11] [RQ15]
    ovr[0].direction_override_enable    = serial_in.serial0_receiver_on; // [RQ10]
    ovr[0].direction_override_value     = 1'b0;
    ovr[0].input_enable_override_enable = pc_enable[0]; // [RQ12]
    ovr[0].input_enable_override_value  = 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_cell
      pin_override_cell u_cell (
        .ovr                   (ovr[g]),
        .data_bit              (st.data[g]),
        .dir_bit               (st.dir[g]),
        .global_pullup_disable (st.global_pullup_disable),
        .buffers_off           (input_buffers_off),
        .pullup_on             (cell_pullup[g]),
        .drive_on              (cell_drive[g]),
        .drive_value           (cell_value[g]),
        .input_on              (cell_input[g])
      );
    end
  endgenerate

  // gated digital input as the peripherals see it
  assign pin_di = st.sync_second & st.pad_input_on;

  // ---------------- next state ----------------
  always_comb begin
    st_next = st;

    // two-flop synchroniser on the pads
    st_next.sync_first  = pad_in;
    st_next.sync_second = st.sync_first;

    // register writes take effect at the access edge
    if (wr_access) begin
      if (apb_in.paddr == `PD_OFF_DATA) begin
        st_next.data = apb_in.pwdata[7:0];
      end else if (apb_in.paddr == `PD_OFF_DIR) begin
        st_next.dir = apb_in.pwdata[7:0];
      end else if (apb_in.paddr == `PD_OFF_CTRL) begin
        st_next.global_pullup_disable    = apb_in.pwdata[`PD_CTRL_PUD_BIT];
        st_next.pin_change_group3_enable = apb_in.pwdata[`PD_CTRL_GRP_BIT];
      end else if (apb_in.paddr == `PD_OFF_MASK) begin
        st_next.mask = apb_in.pwdata[7:0];
      end
    end

    if (rd_setup) begin
      st_next.prdata = rd_value;
    end

    // pad controls registered so the pads never see decode glitches
    st_next.pad_pullup   = cell_pullup & ~cell_drive; // [RQ15]
    st_next.pad_oe       = cell_drive; // [RQ1] [RQ2] [RQ4] [RQ5]
    st_next.pad_out      = cell_value;
    st_next.pad_input_on = cell_input;

    // peripheral inputs
    st_next.timer1_capture_trigger = pin_di[6]; // [RQ3]
    st_next.serial0_receive_line   = pin_di[0]; // [RQ10]
    st_next.serial1_receive_line   = pin_di[2]; // [RQ8]
    st_next.serial1_external_clock = xck_slave & pin_di[4]; // [RQ6]
    st_next.external_irq_zero      = pin_di[2]; // [RQ14]
    st_next.external_irq_one       = pin_di[3]; // [RQ13]
    st_next.pin_change_source      = pin_di; // [RQ12]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st                          <= '0;
      st.data                     <= `PD_RST_DATA;
      st.dir                      <= `PD_RST_DIR;
      st.global_pullup_disable    <= `PD_RST_PUD;
      st.pin_change_group3_enable <= `PD_RST_GRP;
      st.mask                     <= `PD_RST_MASK;
    end else begin
      st <= st_next;
    end
  end

  // ---------------- outputs ----------------
  assign prdata                 = st.prdata;
  assign pad_out                = st.pad_out;
  assign pad_oe                 = st.pad_oe;
  assign pad_pullup             = st.pad_pullup;
  assign pad_input_on           = st.pad_input_on;
  assign timer1_capture_trigger = st.timer1_capture_trigger;
  assign serial0_receive_line   = st.serial0_receive_line;
  assign serial1_receive_line   = st.serial1_receive_line;
  assign serial1_external_clock = st.serial1_external_clock;
  assign external_irq_zero      = st.external_irq_zero;
  assign external_irq_one       = st.external_irq_one;
  assign pin_change_source      = st.pin_change_source;

endmodule : port_d_alternate_function_override
`default_nettype wire

//--- dv/far_side_model.sv
// behavioural timers and serial units facing the port d block
`timescale 1ns/1ps
`default_nettype none
module far_side_model
  import pdmux_pkg::*;
(
  // clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // settings from the bench
  input  wire pdmux_pkg::timer_cmp_t  t_cfg,
  input  wire pdmux_pkg::serial_ctl_t s_cfg,
  input  wire logic                   toggle,
  // towards the block
  output var pdmux_pkg::timer_cmp_t   t_out,
  output var pdmux_pkg::serial_ctl_t  s_out
);
  logic ph;
  // waveforms flip each cycle on request, so a stale copy cannot pass
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph    <= 1'b0;
      t_out <= '0;
      s_out <= '0;
    end else begin
      ph    <= toggle & ~ph;
      t_out <= t_cfg ^ {4{1'b0, ph}};
      s_out <= s_cfg ^ {1'b0, ph, 2'b00, ph, 2'b00, ph};
    end
  end
endmodule : far_side_model
`default_nettype wire

//--- dv/pdmux_check_sva.sv
// pin-level assertions for the port d block
`timescale 1ns/1ps
`default_nettype none
module pdmux_check
  import pdmux_pkg::*;
#(
  parameter int PINS = 8
) (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic [PINS-1:0]        pad_out,
  input wire logic [PINS-1:0]        pad_oe,
  input wire logic [PINS-1:0]        pad_input_on,
  input wire pdmux_pkg::timer_cmp_t  timer_in,
  input wire pdmux_pkg::serial_ctl_t serial_in,
  input wire logic                   external_irq_zero_en,
  input wire logic                   external_irq_one_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  tx1_drive_a: assert property (serial_in.serial1_transmitter_on |=> pad_oe[3] &&
    pad_out[3] == $past(serial_in.serial1_transmit_line)) else $error("pin 3 not sending");
  tx0_drive_a: assert property (serial_in.serial0_transmitter_on |=> pad_oe[1] &&
    pad_out[1] == $past(serial_in.serial0_transmit_line)) else $error("pin 1 not sending");
  rx1_input_a: assert property (serial_in.serial1_receiver_on |=> !pad_oe[2])
    else $error("pin 2 drives while receiving");
  rx0_input_a: assert property (serial_in.serial0_receiver_on |=> !pad_oe[0])
    else $error("pin 0 drives while receiving");
  t2a_wave_a: assert property (timer_in.timer2_compare_a_en ##1 pad_oe[7] |->
    pad_out[7] == $past(timer_in.timer2_compare_a_out)) else $error("pin 7 wave wrong");
  t2b_wave_a: assert property (timer_in.timer2_compare_b_en ##1 pad_oe[6] |->
    pad_out[6] == $past(timer_in.timer2_compare_b_out)) else $error("pin 6 wave wrong");
  t1a_wave_a: assert property (timer_in.timer1_compare_a_en ##1 pad_oe[5] |->
    pad_out[5] == $past(timer_in.timer1_compare_a_out)) else $error("pin 5 wave wrong");
  t1b_wave_a: assert property (timer_in.timer1_compare_b_en && !serial_in.serial1_sync_mode
    ##1 pad_oe[4] |-> pad_out[4] == $past(timer_in.timer1_compare_b_out))
    else $error("pin 4 wave wrong");
  irq1_buf_a: assert property (external_irq_one_en |=> pad_input_on[3])
    else $error("pin 3 buffer off");
  irq0_buf_a: assert property (external_irq_zero_en[*2] |-> pad_input_on[2])
    else $error("pin 2 buffer off");
  cover property (serial_in.serial1_transmitter_on ##1 pad_oe[3]);
  cover property (timer_in.timer2_compare_a_en ##1 pad_oe[7]);
  cover property (external_irq_one_en ##1 pad_input_on[3]);
endmodule : pdmux_check
bind port_d_alternate_function_override pdmux_check #(.PINS(PINS)) i_check (
  .pclk(pclk), .presetn(presetn), .pad_out(pad_out), .pad_oe(pad_oe),
  .pad_input_on(pad_input_on), .timer_in(timer_in), .serial_in(serial_in),
  .external_irq_zero_en(external_irq_zero_en), .external_irq_one_en(external_irq_one_en));
`default_nettype wire

//--- dv/port_d_alternate_function_override_bench.sv
// self-checking bench for the port d override block
`timescale 1ns/1ps
`default_nettype none
`include "pdmux_consts.svh"
module port_d_alternate_function_override_bench;
  import pdmux_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, bufs_off = 1'b0, toggle = 1'b0;
  logic        irq0_en = 1'b0, irq1_en = 1'b0, pready, pslverr, rerr;
  logic        cap, rx0, rx1, xck, irq0, irq1;
  logic [31:0] prdata, rdat;
  logic [7:0]  pad_drv = 8'h00, pad_out, pad_oe, pull, inon, pcs, pad_wire;
  apb_req_t    apb = '0;
  timer_cmp_t  tcfg = '0, tmr;
  serial_ctl_t scfg = '0, ser;
  int          n_errors = 0, tests_run = 0, cycles = 0;
  // the pad wire: our driver yields wherever the block drives
  assign pad_wire = (pad_oe & pad_out) | (~pad_oe & pad_drv);
  always #12.5 pclk = ~pclk;
  far_side_model i_far (.pclk(pclk), .presetn(presetn), .t_cfg(tcfg), .s_cfg(scfg),
    .toggle(toggle), .t_out(tmr), .s_out(ser));
  port_d_alternate_function_override #(.PINS(8)) i_dut (.pclk(pclk), .presetn(presetn),
    .apb_in(apb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_wire),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pull), .pad_input_on(inon),
    .input_buffers_off(bufs_off), .timer_in(tmr), .timer1_capture_trigger(cap),
    .serial_in(ser), .serial0_receive_line(rx0), .serial1_receive_line(rx1),
    .serial1_external_clock(xck), .external_irq_zero_en(irq0_en),
    .external_irq_one_en(irq1_en), .external_irq_zero(irq0), .external_irq_one(irq1),
    .pin_change_source(pcs));
  task automatic wrap_up();
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
    apb.paddr  <= a;
    apb.pwrite <= wr;
    apb.pwdata <= d;
    apb.psel   <= 1'b1;
    @(posedge pclk);
    apb.penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    apb.psel    <= 1'b0;
    apb.penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0000_0000);
    check(rdat, exp);
  endtask : rd
  task automatic settle();
    repeat (6) @(posedge pclk);
  endtask : settle
  task automatic t_reset();
    rd(`PD_OFF_DATA, 32'h0000_0000);
    rd(`PD_OFF_DIR, 32'h0000_0000);
    rd(`PD_OFF_CTRL, 32'h0000_0000);
    rd(`PD_OFF_MASK, 32'h0000_0000);
    rd(32'h0000_0040, 32'h0000_0000);
    check({rerr, pad_oe, pull}, 17'h1_0000);
  endtask : t_reset
  task automatic t_pullup();
    xfer(1'b1, `PD_OFF_DATA, 32'h0000_00FF);
    settle();
    check(pull, 8'hFF);
    xfer(1'b1, `PD_OFF_CTRL, 32'h0000_0001);
    settle();
    check(pull, 8'h00);
    xfer(1'b1, `PD_OFF_CTRL, 32'h0000_0000);
  endtask : t_pullup
  task automatic t_serial();
    xfer(1'b1, `PD_OFF_DIR, 32'h0000_0005);
    xfer(1'b1, `PD_OFF_DATA, 32'h0000_0005);
    pad_drv <= 8'h04;
    scfg    <= 8'hFC;
    settle();
    check(pad_oe[3:0], 4'hA);
    check({pad_out[3], pad_out[1], pull[2], pull[0]}, 4'hF);
    check({rx1, rx0}, 2'b10);
    rd(`PD_OFF_STATUS, 32'h0000_000A);
    rd(`PD_OFF_PINS, 32'h0000_000E);
    xfer(1'b1, `PD_OFF_CTRL, 32'h0000_0001);
    settle();
    check({pull[2], pull[0]}, 2'b00);
    xfer(1'b1, `PD_OFF_CTRL, 32'h0000_0000);
    scfg <= '0;
  endtask : t_serial
  task automatic t_timer();
    xfer(1'b1, `PD_OFF_DIR, 32'h0000_00F0);
    xfer(1'b1, `PD_OFF_DATA, 32'h0000_0000);
    tcfg <= 8'hFF;
    settle();
    check({pad_oe[7:4], pad_out[7:4]}, 8'hFF);
    scfg <= 8'h02;
    settle();
    check(pad_out[7:4], 4'hE);
    xfer(1'b1, `PD_OFF_DIR, 32'h0000_0000);
    pad_drv <= 8'h10;
    settle();
    check({pad_oe[7:4], xck}, 5'h01);
    scfg <= '0;
    settle();
    check(xck, 1'b0);
    xfer(1'b1, `PD_OFF_DIR, 32'h0000_00F0);
    toggle <= 1'b1;
    repeat (20) @(posedge pclk);
    toggle <= 1'b0;
    tcfg   <= '0;
  endtask : t_timer
  task automatic t_inputs();
    xfer(1'b1, `PD_OFF_DIR, 32'h0000_0000);
    xfer(1'b1, `PD_OFF_MASK, 32'h0000_00FF);
    xfer(1'b1, `PD_OFF_CTRL, 32'h0000_0002);
    bufs_off <= 1'b1;
    pad_drv  <= 8'hC9;
    settle();
    check({inon, pcs, cap}, {16'hFFC9, 1'b1});
    xfer(1'b1, `PD_OFF_CTRL, 32'h0000_0000);
    settle();
    check(inon, 8'h00);
    irq0_en <= 1'b1;
    irq1_en <= 1'b1;
    settle();
    check({inon, irq1, irq0}, {8'h0C, 2'b10});
    pad_drv <= 8'h04;
    settle();
    check({irq1, irq0}, 2'b01);
    bufs_off <= 1'b0;
    // interrupt enables dropped so a later reset starts from idle inputs
    irq0_en  <= 1'b0;
    irq1_en  <= 1'b0;
  endtask : t_inputs
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_pullup();
    t_serial();
    t_timer();
    t_inputs();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // mask was left at all ones, so only a real reset reads zero here
    rd(`PD_OFF_MASK, 32'h0000_0000);
    wrap_up();
  end
endmodule : port_d_alternate_function_override_bench
`default_nettype wire
